// ==== core/ready_route.sv ====
// Purpose: Ready flag and serial shift routing of a sigma-delta converter
// Assumes: SCLK and DIN sampled by SYS_CLK, MCLK_EN is a one-cycle pulse
// Notes: Frame select input is active low, hold it low for three-wire use
`timescale 1ns/1ps
`include "ready_route_cfg.svh"

module ready_route #(
  parameter int HOLD_CYCLES = `HOLD_MCLK_PERIODS
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic MCLK_EN,
  input wire ready_route_pkg::result_t RESULT,
  input wire logic CAL_DONE,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  output logic RESULT_READY_N,
  output logic [7:0] SETUP_REG,
  output logic [6:0] COMM_REG,
  output logic [1:0] REGISTER_SELECT
);

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  logic [1:0] sclk_s;
  logic [1:0] din_s;
  logic [1:0] cs_s;
  logic sclk_d;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      // Idle high, so no false edge follows reset
      sclk_s <= 2'h3;
      din_s <= 2'h3;
      cs_s <= 2'h3;
      sclk_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], SCLK};
      din_s <= {din_s[0], DIN};
      cs_s <= {cs_s[0], CS_N};
      sclk_d <= sclk_s[1];
    end
  end
  wire sel = ~cs_s[1];
  // Host shifts out on falling edge, device samples on rising edge
  wire rise = sel & sclk_s[1] & ~sclk_d;
  wire fall = sel & ~sclk_s[1] & sclk_d;
  wire din_b = din_s[1];

  // ***************************************************
  // Ready flag and data register update
  // ***************************************************
  logic [15:0] data_reg;
  logic [15:0] pend_word;
  logic pend;
  logic unread;
  logic [15:0] hold_cnt;
  logic data_read_done;
  logic reading_data;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      RESULT_READY_N <= 1'b1;
      data_reg <= 16'h0000;
      pend_word <= 16'h0000;
      pend <= 1'b0;
      unread <= 1'b0;
      hold_cnt <= 16'h0000;
    end else begin
      if (RESULT.valid && !unread) begin
        // Update deferred while the data register is being read
        if (reading_data) begin
          pend <= 1'b1;
          pend_word <= RESULT.word;
        end else begin
          data_reg <= RESULT.word;
          RESULT_READY_N <= 1'b0;
          unread <= 1'b1;
          // Newer result replaces any word still waiting
          pend <= 1'b0;
        end
      end else if (RESULT.valid) begin
        RESULT_READY_N <= 1'b1;
        pend <= 1'b1;
        pend_word <= RESULT.word;
        hold_cnt <= 16'(HOLD_CYCLES);
      end else if (pend && !reading_data) begin
        if (hold_cnt != 16'h0000) begin
          if (MCLK_EN) hold_cnt <= hold_cnt - 16'h0001;
        end else begin
          data_reg <= pend_word;
          pend <= 1'b0;
          unread <= 1'b1;
          RESULT_READY_N <= 1'b0;
        end
      end else if (CAL_DONE) begin
        RESULT_READY_N <= 1'b0;
      end else if (data_read_done) begin
        RESULT_READY_N <= 1'b1;
        unread <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Serial interface
  // ***************************************************
  ready_route_pkg::link_state_t state;
  logic [15:0] in_sh;
  logic [15:0] out_sh;
  logic [4:0] bit_cnt;
  logic [5:0] ones_cnt;
  logic [4:0] len;
  logic [7:0] test_reg;
  assign reading_data = (state == ready_route_pkg::ST_READ) &&
    (REGISTER_SELECT == `SEL_DATA);
  assign len = (REGISTER_SELECT == `SEL_DATA) ? 5'(`DATA_WIDTH) :
    5'(`COMM_WIDTH);
  assign data_read_done = reading_data && rise && (bit_cnt == len - 5'h01);

  // Saturating, so a long high line cannot wrap

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ones_cnt <= 6'h00;
    end else if (rise) begin
      ones_cnt <= din_b ? ((ones_cnt == 6'(`RESYNC_ONES)) ? ones_cnt :
        ones_cnt + 6'h01) : 6'h00;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state <= ready_route_pkg::ST_CMD;
      bit_cnt <= 5'h00;
      in_sh <= 16'h0000;
      out_sh <= 16'h0000;
      COMM_REG <= `COMM_RESET;
      REGISTER_SELECT <= `SEL_COMM;
      SETUP_REG <= `SETUP_RESET;
      test_reg <= 8'h00;
      DOUT <= 1'b1;
    end else if (rise && din_b && ones_cnt == 6'(`RESYNC_ONES - 1)) begin
      state <= ready_route_pkg::ST_CMD;
      bit_cnt <= 5'h00;
    end else begin
      case (state)
        ready_route_pkg::ST_CMD: begin
          if (rise) begin
            // Leading zero needed before the command bits are taken
            if (bit_cnt == 5'h00) begin
              if (!din_b) bit_cnt <= 5'h01;
            end else if (bit_cnt == 5'(`COMM_WIDTH - 1)) begin
              bit_cnt <= 5'h00;
              COMM_REG <= {in_sh[5:0], din_b};
              REGISTER_SELECT <= in_sh[`BIT_SEL_HI-1:`BIT_SEL_LO-1];
              if (in_sh[`BIT_RW-1]) begin
                state <= ready_route_pkg::ST_READ;
                case (in_sh[`BIT_SEL_HI-1:`BIT_SEL_LO-1])
                  `SEL_COMM: out_sh <= {~RESULT_READY_N ? 1'b0 : 1'b1,
                    in_sh[5:0], din_b, 8'h00};
                  `SEL_SETUP: out_sh <= {SETUP_REG, 8'h00};
                  `SEL_TEST: out_sh <= {test_reg, 8'h00};
                  default: out_sh <= data_reg;
                endcase
              end else begin
                state <= ready_route_pkg::ST_WRITE;
              end
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
            in_sh <= {in_sh[14:0], din_b};
          end
        end
        ready_route_pkg::ST_WRITE: begin
          if (rise) begin
            in_sh <= {in_sh[14:0], din_b};
            if (bit_cnt == len - 5'h01) begin
              bit_cnt <= 5'h00;
              state <= ready_route_pkg::ST_CMD;
              case (REGISTER_SELECT)
                `SEL_SETUP: SETUP_REG <= {in_sh[6:0], din_b};
                `SEL_TEST: test_reg <= {in_sh[6:0], din_b};
                `SEL_COMM: COMM_REG <= {in_sh[5:0], din_b};
                default: ;
              endcase
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
        end
        ready_route_pkg::ST_READ: begin
          // DOUT keeps its last bit once the word is out
          if (fall) DOUT <= out_sh[15];
          if (rise) begin
            out_sh <= {out_sh[14:0], 1'b0};
            if (bit_cnt == len - 5'h01) begin
              bit_cnt <= 5'h00;
              state <= ready_route_pkg::ST_CMD;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
        end
        default: state <= ready_route_pkg::ST_CMD;
      endcase
    end
  end

endmodule : ready_route

// ==== common/ready_route_cfg.svh ====
// Purpose: Constants for the ready flag and serial register routing
// Assumes: 125 MHz system clock
// Notes: Hold count in MCLK_EN pulses, resync count in SCLK rising edges
`ifndef READY_ROUTE_CFG_SVH
`define READY_ROUTE_CFG_SVH
`define SEL_COMM 2'h0
`define SEL_SETUP 2'h1
`define SEL_TEST 2'h2
`define SEL_DATA 2'h3
`define HOLD_MCLK_PERIODS 500
`define RESYNC_ONES 32
`define SETUP_RESET 8'h28
`define COMM_RESET 7'h00
`define COMM_WIDTH 8
`define DATA_WIDTH 16
`define BIT_RW 3
`define BIT_SEL_HI 5
`define BIT_SEL_LO 4
`endif

// ==== common/ready_route_pkg.sv ====
// Purpose: Shared types for the ready flag and serial routing block
// Assumes: Nothing beyond the cfg header
// Notes: Types only
package ready_route_pkg;
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } link_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } result_t;
endpackage : ready_route_pkg

// ==== testbench/rr_assertions.sv ====
// Purpose: Port checks for ready_route
// Assumes: Sync reset, three-wire host
// Notes: Bound after endmodule
`timescale 1ns/1ps
`include "ready_route_cfg.svh"
// ******
// Checks
// ******
module rr_chk #(parameter int HOLD_CYCLES = 4) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic MCLK_EN,
  input wire ready_route_pkg::result_t RESULT,
  input wire logic CAL_DONE,
  input wire logic SCLK,
  input wire logic DOUT,
  input wire logic RESULT_READY_N,
  input wire logic [7:0] SETUP_REG,
  input wire logic [6:0] COMM_REG,
  input wire logic [1:0] REGISTER_SELECT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  wire rd = REGISTER_SELECT == `SEL_DATA && COMM_REG[`BIT_RW];
  // Helper flags: a pending word, a hold in progress, ready low by calibration
  logic waiting;
  logic hold_seen;
  logic cal_low;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      waiting <= 1'b0;
      hold_seen <= 1'b0;
      cal_low <= 1'b0;
    end else begin
      if (RESULT.valid) waiting <= 1'b1;
      else if ($fell(RESULT_READY_N)) waiting <= 1'b0;
      if (RESULT.valid && !RESULT_READY_N) hold_seen <= 1'b1;
      else if (!RESULT_READY_N) hold_seen <= 1'b0;
      if (CAL_DONE) cal_low <= 1'b1;
      else if (RESULT.valid) cal_low <= 1'b0;
    end
  end
  reset_state_a: assert property (disable iff (1'b0) SYS_RST |=>
    RESULT_READY_N && DOUT && SETUP_REG == `SETUP_RESET) else $error("rst");
  new_result_a: assert property (!hold_seen && RESULT.valid &&
    RESULT_READY_N |=> !RESULT_READY_N) else $error("new");
  cal_done_a: assert property (CAL_DONE && !RESULT.valid &&
    !hold_seen |=> !RESULT_READY_N) else $error("cal");
  unread_high_a: assert property (!rd && !cal_low &&
    RESULT.valid && !RESULT_READY_N |=> RESULT_READY_N) else $error("unread");
  fall_cause_a: assert property ($fell(RESULT_READY_N) |->
    waiting || $past(CAL_DONE) || $past(RESULT.valid)) else $error("fall");
  rise_cause_a: assert property ($rose(RESULT_READY_N) |->
    $past(RESULT.valid) || rd) else $error("rise");
  dout_edge_a: assert property ($changed(DOUT) |-> !SCLK)
    else $error("dout");
  setup_load_a: assert property ($changed(SETUP_REG) |->
    REGISTER_SELECT == `SEL_SETUP && !COMM_REG[`BIT_RW]) else $error("setup");
  cover property (RESULT.valid && !RESULT_READY_N);
  cover property (CAL_DONE);
  cover property ($rose(RESULT_READY_N) && rd);
endmodule : rr_chk
bind ready_route rr_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
  .SYS_CLK(SYS_CLK),
  .SYS_RST(SYS_RST),
  .MCLK_EN(MCLK_EN),
  .RESULT(RESULT),
  .CAL_DONE(CAL_DONE),
  .SCLK(SCLK),
  .DOUT(DOUT),
  .RESULT_READY_N(RESULT_READY_N),
  .SETUP_REG(SETUP_REG),
  .COMM_REG(COMM_REG),
  .REGISTER_SELECT(REGISTER_SELECT)
);

// ==== testbench/host_model.sv ====
// Purpose: Serial host on the far side
// Assumes: Link clock 80 ns, idle high
// Notes: Clock stands still between frames
`timescale 1ns/1ps
// ****
// Host
// ****
module host_model (
  input wire logic clk,
  input wire logic dout,
  output logic sclk,
  output logic din
);
  initial begin
    sclk = 1'b1;
    din = 1'b1;
  end
  // MSB first, whole units only
  task automatic xfer(input logic [15:0] tx, input int n,
      output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk) sclk <= 1'b0;
      din <= tx[i];
      repeat (5) @(posedge clk);
      rx = {rx[14:0], dout};
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    din <= ~din; // Released line must not look held
  endtask : xfer
endmodule : host_model

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for ready_route
// Assumes: CS_N held low
// Notes: Hold count cut to 4
`timescale 1ns/1ps
`include "ready_route_cfg.svh"
// *****
// Bench
// *****
module testbench;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic MCLK_EN = 1'b0;
  logic CAL_DONE = 1'b0;
  logic CS_N = 1'b0;
  ready_route_pkg::result_t RESULT = '0;
  logic SCLK, DIN, DOUT, RESULT_READY_N;
  logic [7:0] SETUP_REG;
  logic [6:0] COMM_REG;
  logic [1:0] REGISTER_SELECT;
  logic [15:0] rx;
  int error_cnt = 0;
  int n_checks = 0;
  ready_route #(.HOLD_CYCLES(4)) uut (
    .SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST),
    .MCLK_EN(MCLK_EN),
    .RESULT(RESULT),
    .CAL_DONE(CAL_DONE),
    .SCLK(SCLK),
    .CS_N(CS_N),
    .DIN(DIN),
    .DOUT(DOUT),
    .RESULT_READY_N(RESULT_READY_N),
    .SETUP_REG(SETUP_REG),
    .COMM_REG(COMM_REG),
    .REGISTER_SELECT(REGISTER_SELECT)
  );
  host_model host (.clk(SYS_CLK), .dout(DOUT), .sclk(SCLK), .din(DIN));
  initial forever #4 SYS_CLK = ~SYS_CLK;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask : tick
  task automatic pulse(input logic [15:0] w, input logic cal);
    @(posedge SYS_CLK) RESULT <= '{~cal, w};
    CAL_DONE <= cal;
    @(posedge SYS_CLK) RESULT <= '0;
    CAL_DONE <= 1'b0;
    tick(0);
  endtask : pulse
  task automatic mclk(input int n);
    repeat (n) begin
      @(posedge SYS_CLK) MCLK_EN <= 1'b1;
      @(posedge SYS_CLK) MCLK_EN <= 1'b0;
    end
    tick(1);
  endtask : mclk
  task automatic rw(input logic [7:0] cmd, input logic [15:0] tx, int n);
    host.xfer({8'h00, cmd}, 8, rx);
    host.xfer(tx, n, rx);
    tick(0);
  endtask : rw
  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    tick(3);
    check(RESULT_READY_N, 1'b1);
    check(SETUP_REG, `SETUP_RESET);
    pulse(16'h1234, 1'b0);
    check(RESULT_READY_N, 1'b0);
    pulse(16'hA5C3, 1'b0);
    check(RESULT_READY_N, 1'b1);
    mclk(3);
    check(RESULT_READY_N, 1'b1);
    mclk(1);
    check(RESULT_READY_N, 1'b0);
    rw(8'h38, 16'h0000, 16);
    check(rx, 16'hA5C3);
    check(RESULT_READY_N, 1'b1);
    rw(8'h08, 16'h0000, 8);
    check(rx, 16'h0088);
    rw(8'h10, 16'h005A, 8);
    check(SETUP_REG, 16'h005A);
    rw(8'h18, 16'h0000, 8);
    check(rx, 16'h005A);
    host.xfer(16'hFFFF, 16, rx);
    host.xfer(16'hFFFF, 16, rx);
    rw(8'h20, 16'h00C3, 8);
    check(REGISTER_SELECT, `SEL_TEST);
    rw(8'h28, 16'h0000, 8);
    check(rx, 16'h00C3);
    pulse(16'h0000, 1'b1);
    check(RESULT_READY_N, 1'b0);
    stop_test();
  end
endmodule : testbench
